// File: design/sdmr_regs.vh
`ifndef SDMR_REGS_VH
`define SDMR_REGS_VH
// Operation
// - after warm reset, init steps repeat, then device is ready
// - mode registers undefined after reset; all must be written before use
// - mode sets and DLL reset never touch array contents
// - all command strobes and bank bits low write mode_register_zero
// - A0-A1 pick chop_of_four, burst_of_eight, or per-command via A12
// - A3 picks sequential or interleaved burst order
// - read order from length, type and start column bits
// - chopped read drives four beats then floats for four
// - writes ignore low start bits; chop uses column bit two only
// - fixed chop starts internal write two clocks earlier
// - A2, A4-A6 give read_latency_field; total is additive plus decoded field
// - DLL reset bit self-clears; wait dll_lock_time before reads
// - A9-A11 write recovery; with precharge sets auto_precharge_delay
// - A12 picks frozen DLL slow exit or running DLL fast exit
`define SDMR_BL_MSB 1
`define SDMR_BL_LSB 0
`define SDMR_CL_LOW_BIT 2
`define SDMR_BT_BIT 3
`define SDMR_CL_MSB 6
`define SDMR_CL_LSB 4
`define SDMR_TM_BIT 7
`define SDMR_DLLRST_BIT 8
`define SDMR_WR_MSB 11
`define SDMR_WR_LSB 9
`define SDMR_PPD_BIT 12
`define SDMR_OTF_BIT 12
`define SDMR_BL_FIX8 2'h0
`define SDMR_BL_OTF 2'h1
`define SDMR_BL_FIX4 2'h2
`define SDMR_LAST_BEAT 3'h7
`define SDMR_CHOP_LAST 3'h5
`define SDMR_CLK_PERIOD_NS 100
`define SDMR_RST_HOLD_NS 100
`define SDMR_RST_HOLD_CYC ((`SDMR_RST_HOLD_NS + `SDMR_CLK_PERIOD_NS - 1) / `SDMR_CLK_PERIOD_NS)
`define SDMR_INIT_WAIT_US 500
`define SDMR_DLL_LOCK_CYC 512
`define SDMR_FAST_EXIT_CYC 3
`define SDMR_SLOW_EXIT_CYC 10
`endif

// File: design/sdmr_burst_order.v
`timescale 1ns/100ps
`include "sdmr_regs.vh"
module sdmr_burst_order (
  input  wire       i_write,
  input  wire       i_chop,
  input  wire       i_interleave,
  input  wire [2:0] i_start,
  input  wire [2:0] i_beat,
  output reg  [2:0] o_col
);
  always @* begin
    if (i_write) begin
      if (i_chop) begin
        o_col = {i_start[2], i_beat[1:0]};
      end else begin
        o_col = i_beat;
      end
    end else if (i_interleave) begin
      o_col = i_start ^ i_beat;
    end else begin
      o_col = {i_start[2] ^ i_beat[2], i_start[1:0] + i_beat[1:0]};
    end
  end
endmodule

// File: design/sdmr_lock_timer.v
`timescale 1ns/100ps
module sdmr_lock_timer #(
  parameter CYC = 512,
  parameter CW  = 16
) (
  input  wire i_sys_clk,
  input  wire i_rstn,
  input  wire i_start,
  output wire o_locked
);
  reg [CW-1:0] cnt_ff;
  reg          locked_ff;
  assign o_locked = locked_ff;
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cnt_ff    <= {CW{1'b0}};
      locked_ff <= 1'b0;
    end else if (i_start) begin
      cnt_ff    <= CYC[CW-1:0];
      locked_ff <= 1'b0;
    end else if (cnt_ff != {CW{1'b0}}) begin
      cnt_ff    <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
      locked_ff <= (cnt_ff == {{(CW-1){1'b0}}, 1'b1});
    end
  end
endmodule

// File: design/sdmr_top.v
`timescale 1ns/100ps
`include "sdmr_regs.vh"
module sdmr_top #(
  parameter DLL_LOCK_CYC  = `SDMR_DLL_LOCK_CYC,
  parameter FAST_EXIT_CYC = `SDMR_FAST_EXIT_CYC,
  parameter SLOW_EXIT_CYC = `SDMR_SLOW_EXIT_CYC
) (
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  input  wire        i_cke,
  input  wire        i_cs_n,
  input  wire        i_ras_n,
  input  wire        i_cas_n,
  input  wire        i_we_n,
  input  wire [2:0]  i_ba,
  input  wire [15:0] i_addr,
  input  wire [3:0]  i_additive_latency,
  input  wire [4:0]  i_write_latency,
  input  wire [3:0]  i_precharge_cycles,
  output wire [1:0]  o_burst_len_code,
  output wire        o_burst_interleave,
  output wire [3:0]  o_read_latency_field,
  output wire [4:0]  o_total_read_latency,
  output wire        o_test_mode,
  output wire [4:0]  o_write_recovery,
  output wire [5:0]  o_auto_precharge_delay,
  output wire        o_ppd_fast_exit,
  output wire [3:0]  o_pd_exit_cycles,
  output wire        o_mr0_valid,
  output wire        o_dll_reset,
  output wire        o_dll_locked,
  output wire        o_init_done,
  output wire        o_rd_beat_valid,
  output wire [2:0]  o_rd_beat_col,
  output wire        o_rd_dq_oe,
  output wire        o_wr_beat_valid,
  output wire [2:0]  o_wr_beat_col,
  output wire        o_wr_commit
);

  // read latency field decode; reserved codes give zero
  function [3:0] cl_clocks;
    input [3:0] code;
    begin
      case (code)
        4'h2:    cl_clocks = 4'h5;
        4'h4:    cl_clocks = 4'h6;
        4'h6:    cl_clocks = 4'h7;
        4'h8:    cl_clocks = 4'h8;
        4'hA:    cl_clocks = 4'h9;
        4'hC:    cl_clocks = 4'hA;
        4'hE:    cl_clocks = 4'hB;
        4'h1:    cl_clocks = 4'hC;
        4'h3:    cl_clocks = 4'hD;
        4'h5:    cl_clocks = 4'hE;
        default: cl_clocks = 4'h0;
      endcase
    end
  endfunction

  function [4:0] wr_clocks;
    input [2:0] code;
    begin
      case (code)
        3'h1:    wr_clocks = 5'h05;
        3'h2:    wr_clocks = 5'h06;
        3'h3:    wr_clocks = 5'h07;
        3'h4:    wr_clocks = 5'h08;
        3'h5:    wr_clocks = 5'h0A;
        3'h6:    wr_clocks = 5'h0C;
        3'h7:    wr_clocks = 5'h0E;
        default: wr_clocks = 5'h10;
      endcase
    end
  endfunction

  // latency minus one, floored at zero so the first beat is never lost
  function [4:0] lat_m1;
    input [4:0] lat;
    begin
      if (lat == 5'h00) begin
        lat_m1 = 5'h00;
      end else begin
        lat_m1 = lat - 5'h01;
      end
    end
  endfunction

  reg  [1:0] bl_ff;
  reg        bt_ff;
  reg  [3:0] cl_code_ff;
  reg  [4:0] total_rl_ff;
  reg        tm_ff;
  reg  [4:0] wr_ff;
  reg  [5:0] apd_ff;
  reg        ppd_ff;
  reg  [3:0] pd_exit_ff;
  reg        mr0_valid_ff;
  reg        dll_reset_ff;
  reg        init_done_ff;
  reg        rd_busy_ff;
  reg  [4:0] rd_wait_ff;
  reg  [2:0] rd_beat_ff;
  reg  [2:0] rd_start_ff;
  reg        rd_chop_ff;
  reg        rd_bt_ff;
  reg        rd_vld_ff;
  reg  [2:0] rd_col_ff;
  reg        rd_oe_ff;
  reg        wr_busy_ff;
  reg  [4:0] wr_wait_ff;
  reg  [2:0] wr_beat_ff;
  reg  [2:0] wr_start_ff;
  reg        wr_chop_ff;
  reg        wr_fix4_ff;
  reg        wr_vld_ff;
  reg  [2:0] wr_col_ff;
  reg        wr_commit_ff;
  wire       cmd_ok;
  wire       mrs_mr0;
  wire       mrs_dll;
  wire       rd_cmd;
  wire       wr_cmd;
  wire       chop_sel;
  wire       rd_emit;
  wire       wr_emit;
  wire [2:0] rd_col_w;
  wire [2:0] wr_col_w;
  wire       locked_w;
  wire [2:0] commit_beat;

  assign o_burst_len_code       = bl_ff;
  assign o_burst_interleave     = bt_ff;
  assign o_read_latency_field   = cl_code_ff;
  assign o_total_read_latency   = total_rl_ff;
  assign o_test_mode            = tm_ff;
  assign o_write_recovery       = wr_ff;
  assign o_auto_precharge_delay = apd_ff;
  assign o_ppd_fast_exit        = ppd_ff;
  assign o_pd_exit_cycles       = pd_exit_ff;
  assign o_mr0_valid            = mr0_valid_ff;
  assign o_dll_reset            = dll_reset_ff;
  assign o_dll_locked           = locked_w;
  assign o_init_done            = init_done_ff;
  assign o_rd_beat_valid        = rd_vld_ff;
  assign o_rd_beat_col          = rd_col_ff;
  assign o_rd_dq_oe             = rd_oe_ff;
  assign o_wr_beat_valid        = wr_vld_ff;
  assign o_wr_beat_col          = wr_col_ff;
  assign o_wr_commit            = wr_commit_ff;

  // commands count only while the clock enable input is high on the same edge
  assign cmd_ok  = i_cke & ~i_cs_n;
  assign mrs_mr0 = cmd_ok & ~i_ras_n & ~i_cas_n & ~i_we_n & (i_ba == 3'h0);
  assign mrs_dll = mrs_mr0 & i_addr[`SDMR_DLLRST_BIT];
  assign rd_cmd  = cmd_ok & i_ras_n & ~i_cas_n & i_we_n;
  assign wr_cmd  = cmd_ok & i_ras_n & ~i_cas_n & ~i_we_n;
  assign chop_sel = (bl_ff == `SDMR_BL_FIX4) |
                    ((bl_ff == `SDMR_BL_OTF) & ~i_addr[`SDMR_OTF_BIT]);
  assign rd_emit  = rd_busy_ff & (rd_wait_ff == 5'h00);
  assign wr_emit  = wr_busy_ff & (wr_wait_ff == 5'h00);
  assign commit_beat = wr_fix4_ff ? `SDMR_CHOP_LAST : `SDMR_LAST_BEAT;

  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      bl_ff        <= `SDMR_BL_FIX8;
      bt_ff        <= 1'b0;
      cl_code_ff   <= 4'h0;
      tm_ff        <= 1'b0;
      wr_ff        <= 5'h10;
      ppd_ff       <= 1'b0;
      mr0_valid_ff <= 1'b0;
    end else if (mrs_mr0) begin
      bl_ff        <= i_addr[`SDMR_BL_MSB:`SDMR_BL_LSB];
      bt_ff        <= i_addr[`SDMR_BT_BIT];
      cl_code_ff   <= {i_addr[`SDMR_CL_MSB:`SDMR_CL_LSB], i_addr[`SDMR_CL_LOW_BIT]};
      // test mode only reported; no behaviour is promised under it
      tm_ff        <= i_addr[`SDMR_TM_BIT];
      wr_ff        <= wr_clocks(i_addr[`SDMR_WR_MSB:`SDMR_WR_LSB]);
      ppd_ff       <= i_addr[`SDMR_PPD_BIT];
      mr0_valid_ff <= 1'b1;
    end
  end

  // derived timing, recomputed every clock from the stored fields and the additive latency and precharge inputs
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      total_rl_ff  <= 5'h00;
      apd_ff       <= 6'h00;
      pd_exit_ff   <= 4'h0;
      dll_reset_ff <= 1'b0;
      init_done_ff <= 1'b0;
    end else begin
      total_rl_ff  <= {1'b0, i_additive_latency} + {1'b0, cl_clocks(cl_code_ff)};
      apd_ff       <= {1'b0, wr_ff} + {2'b00, i_precharge_cycles};
      pd_exit_ff   <= ppd_ff ? FAST_EXIT_CYC[3:0] : SLOW_EXIT_CYC[3:0];
      dll_reset_ff <= mrs_dll;
      init_done_ff <= mr0_valid_ff & locked_w & ~mrs_dll;
    end
  end

  sdmr_lock_timer #(
    .CYC (DLL_LOCK_CYC),
    .CW  (16)
  ) u_lock (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_start   (mrs_dll),
    .o_locked  (locked_w)
  );

  // one read in flight; a read during a burst is ignored
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rd_busy_ff  <= 1'b0;
      rd_wait_ff  <= 5'h00;
      rd_beat_ff  <= 3'h0;
      rd_start_ff <= 3'h0;
      rd_chop_ff  <= 1'b0;
      rd_bt_ff    <= 1'b0;
    end else if (!rd_busy_ff) begin
      if (rd_cmd) begin
        rd_busy_ff  <= 1'b1;
        rd_wait_ff  <= lat_m1(total_rl_ff);
        rd_beat_ff  <= 3'h0;
        rd_start_ff <= i_addr[2:0];
        rd_chop_ff  <= chop_sel;
        rd_bt_ff    <= bt_ff;
      end
    end else if (rd_wait_ff != 5'h00) begin
      rd_wait_ff <= rd_wait_ff - 5'h01;
    end else begin
      rd_beat_ff <= rd_beat_ff + 3'h1;
      if (rd_beat_ff == `SDMR_LAST_BEAT) begin
        rd_busy_ff <= 1'b0;
      end
    end
  end

  sdmr_burst_order u_rd_order (
    .i_write      (1'b0),
    .i_chop       (rd_chop_ff),
    .i_interleave (rd_bt_ff),
    .i_start      (rd_start_ff),
    .i_beat       (rd_beat_ff),
    .o_col        (rd_col_w)
  );

  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rd_vld_ff <= 1'b0;
      rd_col_ff <= 3'h0;
      rd_oe_ff  <= 1'b0;
    end else begin
      rd_vld_ff <= rd_emit;
      rd_col_ff <= rd_emit ? rd_col_w : 3'h0;
      rd_oe_ff  <= rd_emit & ~(rd_chop_ff & rd_beat_ff[2]);
    end
  end

  // write beats follow the given write latency; one write in flight
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wr_busy_ff  <= 1'b0;
      wr_wait_ff  <= 5'h00;
      wr_beat_ff  <= 3'h0;
      wr_start_ff <= 3'h0;
      wr_chop_ff  <= 1'b0;
      wr_fix4_ff  <= 1'b0;
    end else if (!wr_busy_ff) begin
      if (wr_cmd) begin
        wr_busy_ff  <= 1'b1;
        wr_wait_ff  <= lat_m1(i_write_latency);
        wr_beat_ff  <= 3'h0;
        wr_start_ff <= i_addr[2:0];
        wr_chop_ff  <= chop_sel;
        wr_fix4_ff  <= (bl_ff == `SDMR_BL_FIX4);
      end
    end else if (wr_wait_ff != 5'h00) begin
      wr_wait_ff <= wr_wait_ff - 5'h01;
    end else begin
      wr_beat_ff <= wr_beat_ff + 3'h1;
      if (wr_beat_ff == `SDMR_LAST_BEAT) begin
        wr_busy_ff <= 1'b0;
      end
    end
  end

  sdmr_burst_order u_wr_order (
    .i_write      (1'b1),
    .i_chop       (wr_chop_ff),
    .i_interleave (1'b0),
    .i_start      (wr_start_ff),
    .i_beat       (wr_beat_ff),
    .o_col        (wr_col_w)
  );

  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wr_vld_ff    <= 1'b0;
      wr_col_ff    <= 3'h0;
      wr_commit_ff <= 1'b0;
    end else begin
      wr_vld_ff    <= wr_emit & ~(wr_chop_ff & wr_beat_ff[2]);
      wr_col_ff    <= wr_emit ? wr_col_w : 3'h0;
      wr_commit_ff <= wr_emit & (wr_beat_ff == commit_beat);
    end
  end

endmodule

// File: bench/sdmr_top_checker.sv
`timescale 1ns/100ps
module sdmr_top_checker #(
  parameter DLL_LOCK_CYC  = 512,
  parameter FAST_EXIT_CYC = 3,
  parameter SLOW_EXIT_CYC = 10
) (
  input wire        i_sys_clk,
  input wire        i_rstn,
  input wire        i_cke,
  input wire        i_cs_n,
  input wire        i_ras_n,
  input wire        i_cas_n,
  input wire        i_we_n,
  input wire [2:0]  i_ba,
  input wire [15:0] i_addr,
  input wire [3:0]  i_precharge_cycles,
  input wire [1:0]  o_burst_len_code,
  input wire        o_burst_interleave,
  input wire [3:0]  o_read_latency_field,
  input wire [4:0]  o_write_recovery,
  input wire [5:0]  o_auto_precharge_delay,
  input wire        o_ppd_fast_exit,
  input wire [3:0]  o_pd_exit_cycles,
  input wire        o_mr0_valid,
  input wire        o_dll_reset,
  input wire        o_dll_locked,
  input wire        o_init_done,
  input wire        o_rd_beat_valid,
  input wire        o_rd_dq_oe,
  input wire        o_wr_beat_valid,
  input wire        o_wr_commit
);
  wire       mrs = i_cke & ~(i_cs_n | i_ras_n | i_cas_n | i_we_n) & (i_ba == 3'h0);
  reg  [9:0] lk_cnt_ff;
  // counts edges from the dll reset request until lock is reported
  always @(posedge i_sys_clk) begin
    if (!i_rstn) lk_cnt_ff <= 10'h0;
    else if (mrs & i_addr[8]) lk_cnt_ff <= 10'h1;
    else if (lk_cnt_ff != 10'h0 && !o_dll_locked) lk_cnt_ff <= lk_cnt_ff + 10'h1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  mr0_cap_a: assert property (mrs |=> o_mr0_valid && o_burst_len_code == $past(i_addr[1:0])
    && o_burst_interleave == $past(i_addr[3]) && o_ppd_fast_exit == $past(i_addr[12])
    && o_read_latency_field == $past({i_addr[6:4], i_addr[2]})) else $error("fields not captured");
  mr0_hold_a: assert property (!mrs |=> $stable(o_burst_len_code) && $stable(o_ppd_fast_exit))
    else $error("fields changed without mode set");
  dll_pulse_a: assert property (mrs && i_addr[8] |=> o_dll_reset ##1 !o_dll_reset)
    else $error("dll reset pulse wrong");
  dll_cause_a: assert property (o_dll_reset |-> $past(mrs && i_addr[8]))
    else $error("dll reset without request");
  dll_lock_a: assert property ($rose(o_dll_locked) |-> lk_cnt_ff == DLL_LOCK_CYC + 1)
    else $error("dll lock time wrong");
  init_done_a: assert property ($past(i_rstn) |-> o_init_done ==
    $past(o_mr0_valid && o_dll_locked && !(mrs && i_addr[8]))) else $error("init done wrong");
  ap_delay_a: assert property ($past(i_rstn) |-> o_auto_precharge_delay ==
    $past({1'b0, o_write_recovery} + {2'h0, i_precharge_cycles})) else $error("ap delay wrong");
  pd_exit_a: assert property ($past(i_rstn) |-> o_pd_exit_cycles ==
    ($past(o_ppd_fast_exit) ? FAST_EXIT_CYC : SLOW_EXIT_CYC)) else $error("exit delay wrong");
  rd_burst_a: assert property ($rose(o_rd_beat_valid) |-> o_rd_beat_valid [*8] ##1 !o_rd_beat_valid)
    else $error("read burst not eight beats");
  chop_oe_a: assert property ($rose(o_rd_beat_valid) && o_burst_len_code == 2'h2 |->
    o_rd_dq_oe [*4] ##1 !o_rd_dq_oe [*4]) else $error("chopped read drive wrong");
  wr_commit_a: assert property ($rose(o_wr_beat_valid) |-> if (o_burst_len_code == 2'h2)
    ##5 o_wr_commit else ##7 o_wr_commit) else $error("write commit timing wrong");
endmodule

// File: bench/sdmr_ctrl_model.sv
`timescale 1ns/100ps
module sdmr_ctrl_model (
  input  wire        i_sys_clk,
  output reg         o_rstn,
  output reg         o_cke,
  output reg         o_cs_n,
  output reg         o_ras_n,
  output reg         o_cas_n,
  output reg         o_we_n,
  output reg  [2:0]  o_ba,
  output reg  [15:0] o_addr
);
  initial begin
    o_rstn = 1'b0;
    o_cke = 1'b0;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_ba = 3'h0;
    o_addr = 16'h0;
  end
  task cmd(input [3:0] c, input [2:0] ba, input [15:0] a);
    begin
      @(negedge i_sys_clk);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
      o_ba = ba;
      o_addr = a;
      @(negedge i_sys_clk);
      // deselected lines must not keep the last value
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
      o_ba = ~ba;
      o_addr = ~a;
    end
  endtask
  task mrs(input [2:0] ba, input [15:0] a);
    begin
      // full word, reserved and test bits zero
      cmd(4'h0, ba, a & 16'h1F7F);
      repeat (4) @(negedge i_sys_clk);
    end
  endtask
  task rst_seq(input [15:0] a0);
    begin
      // reset held with clock enable already low
      o_cke = 1'b0;
      o_rstn = 1'b0;
      repeat (8) @(negedge i_sys_clk);
      o_rstn = 1'b1;
      repeat (5) @(negedge i_sys_clk);
      o_cke = 1'b1;
      repeat (5) @(negedge i_sys_clk);
      // order two, three, one, zero with dll reset
      mrs(3'h2, a0);
      mrs(3'h3, a0);
      mrs(3'h1, a0);
      mrs(3'h0, a0 | 16'h0100);
    end
  endtask
endmodule

// File: bench/sdmr_top_tb.sv
`timescale 1ns/100ps
module sdmr_top_tb;
  reg         i_sys_clk;
  reg  [3:0]  al;
  reg  [4:0]  wl;
  reg  [3:0]  pc;
  reg  [31:0] lfsr;
  reg  [15:0] a;
  reg  [3:0]  f;
  reg  [1:0]  bl;
  integer     errors, cmp_count, t;
  wire        rstn, cke, cs_n, ras_n, cas_n, we_n;
  wire [2:0]  ba;
  wire [15:0] addr;
  sdmr_ctrl_model u_ctrl (.i_sys_clk(i_sys_clk), .o_rstn(rstn), .o_cke(cke), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
  sdmr_top #(.DLL_LOCK_CYC(8)) DUT (.i_sys_clk(i_sys_clk), .i_rstn(rstn), .i_cke(cke),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr),
    .i_additive_latency(al), .i_write_latency(wl), .i_precharge_cycles(pc),
    .o_burst_len_code(), .o_burst_interleave(), .o_read_latency_field(),
    .o_total_read_latency(), .o_test_mode(), .o_write_recovery(), .o_auto_precharge_delay(),
    .o_ppd_fast_exit(), .o_pd_exit_cycles(), .o_mr0_valid(), .o_dll_reset(), .o_dll_locked(),
    .o_init_done(), .o_rd_beat_valid(), .o_rd_beat_col(), .o_rd_dq_oe(), .o_wr_beat_valid(),
    .o_wr_beat_col(), .o_wr_commit());
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [3:0] ecl(input [3:0] c);
    ecl = c[0] ? ((c < 4'h7) ? 4'hC + c[3:1] : 4'h0) : ((c != 4'h0) ? 4'h4 + c[3:1] : 4'h0);
  endfunction
  function [4:0] ewr(input [2:0] c);
    ewr = (c == 3'h0) ? 5'h10 : (c < 3'h5) ? {2'h0, c} + 5'h4 : {1'b0, c, 1'b0};
  endfunction
  function [2:0] ecol(input w, input ch, input il, input [2:0] s, input [2:0] b);
    if (w) ecol = ch ? ((s & 3'h4) | (b & 3'h3)) : b;
    else if (il) ecol = s ^ b;
    else ecol = ((s ^ b) & 3'h4) | ((s + b) & 3'h3);
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task test_done;
    begin
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task burst(input w, input [2:0] s, input a12, input [1:0] bc, input il, input [4:0] lat);
    reg     ch;
    integer n, b;
    begin
      ch = (bc == 2'h2) || (bc == 2'h1 && !a12);
      u_ctrl.cmd(w ? 4'h4 : 4'h5, 3'h0, {3'h0, a12, 9'h0, s});
      n = 0;
      while (!(w ? DUT.o_wr_beat_valid : DUT.o_rd_beat_valid) && n < 40) begin
        @(negedge i_sys_clk);
        n = n + 1;
      end
      chk("latency", lat, n);
      for (b = 0; b < 8; b = b + 1) begin
        if (w) begin
          chk("wr_valid", !ch || b < 4, DUT.o_wr_beat_valid);
          if (!ch || b < 4) chk("wr_col", ecol(1, ch, il, s, b), DUT.o_wr_beat_col);
        end else begin
          chk("rd_oe", !ch || b < 4, DUT.o_rd_dq_oe);
          if (!ch || b < 4) chk("rd_col", ecol(0, ch, il, s, b), DUT.o_rd_beat_col);
        end
        @(negedge i_sys_clk);
      end
      repeat (2) @(negedge i_sys_clk);
    end
  endtask
  initial begin
    #500000;
    errors = errors + 1;
    test_done;
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    lfsr = 32'h46CF4D30;
    al = 4'h0;
    wl = 5'h3;
    pc = 4'h4;
    u_ctrl.rst_seq(16'h0001);
    chk("locked_early", 1'b0, DUT.o_dll_locked);
    repeat (6) @(negedge i_sys_clk);
    chk("init_done", 1'b1, DUT.o_init_done);
    for (t = 0; t < 24; t = t + 1) begin
      lfsr = nxt(lfsr);
      f = (ecl(lfsr[3:0]) == 4'h0) ? 4'h2 : lfsr[3:0];
      bl = t % 3;
      al = (lfsr[9:8] == 2'h3) ? 4'h0 : {2'h0, lfsr[9:8]};
      wl = {2'h0, lfsr[26:24]} + 5'h1;
      pc = lfsr[23:20];
      a = {3'h0, lfsr[16], t[2:0], 2'h0, f[3:1], lfsr[5], f[0], bl};
      u_ctrl.mrs(3'h0, a);
      chk("wr_rec", ewr(a[11:9]), DUT.o_write_recovery);
      chk("cl_field", f, DUT.o_read_latency_field);
      chk("rd_lat", al + ecl(f), DUT.o_total_read_latency);
      chk("test_mode", 1'b0, DUT.o_test_mode);
      burst(1'b0, lfsr[30:28], lfsr[31], bl, a[3], al + ecl(f));
      burst(1'b1, lfsr[14:12], lfsr[15], bl, a[3], wl);
    end
    u_ctrl.mrs(3'h4, 16'h0003);
    chk("bl_keep", bl, DUT.o_burst_len_code);
    // warm reset in mid-run: the full init sequence must bring the part back
    u_ctrl.rst_seq(16'h0001);
    repeat (6) @(negedge i_sys_clk);
    chk("warm_init", 1'b1, DUT.o_init_done);
    chk("warm_bl", 2'h1, DUT.o_burst_len_code);
    test_done;
  end
endmodule
bind sdmr_top sdmr_top_checker #(.DLL_LOCK_CYC(DLL_LOCK_CYC), .FAST_EXIT_CYC(FAST_EXIT_CYC),
  .SLOW_EXIT_CYC(SLOW_EXIT_CYC)) u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cke(i_cke),
  .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_ba(i_ba),
  .i_addr(i_addr), .i_precharge_cycles(i_precharge_cycles), .o_burst_len_code(o_burst_len_code),
  .o_burst_interleave(o_burst_interleave), .o_read_latency_field(o_read_latency_field),
  .o_write_recovery(o_write_recovery), .o_auto_precharge_delay(o_auto_precharge_delay),
  .o_ppd_fast_exit(o_ppd_fast_exit), .o_pd_exit_cycles(o_pd_exit_cycles),
  .o_mr0_valid(o_mr0_valid), .o_dll_reset(o_dll_reset), .o_dll_locked(o_dll_locked),
  .o_init_done(o_init_done), .o_rd_beat_valid(o_rd_beat_valid), .o_rd_dq_oe(o_rd_dq_oe),
  .o_wr_beat_valid(o_wr_beat_valid), .o_wr_commit(o_wr_commit));
